/* File: acc_load_core.v */
// Accumulator load from stack pointer, interrupt and timer control registers
// Operation
// - Stack pointer bits 2..0 into accumulator bits 2..0
// - Stack pointer load clears accumulator bit 3
// - Load whole interrupt control A, one cycle
// - Load whole interrupt control B, one cycle
// - Load whole timer control A, one cycle
// - Load whole timer control B, one cycle
`timescale 1ns/1ps
`default_nettype none
`include "acc_load_defines.vh"

module acc_load_core #(
  parameter ACC_W = `ACC_W,
  parameter SP_W = `SP_W
) (
  input wire ref_clk,
  input wire rst_n,
  // Decoded instruction word, one word per cycle
  input wire [`INSTR_W-1:0] instr_word,
  input wire instr_valid,
  // Source register read buses
  input wire [SP_W-1:0] stack_pointer,
  input wire [ACC_W-1:0] irq_ctrl_a,
  input wire [ACC_W-1:0] irq_ctrl_b,
  input wire [ACC_W-1:0] tmr_ctrl_a,
  input wire [ACC_W-1:0] tmr_ctrl_b,
  // Accumulator write path used by the rest of the core
  input wire acc_ext_wr,
  input wire [ACC_W-1:0] acc_ext_data,
  // Carry flag write path used by the rest of the core
  input wire carry_ext_wr,
  input wire carry_ext_data,
  // Outputs, all from flip-flops
  output reg [ACC_W-1:0] acc_reg,
  output reg carry_flag_reg,
  output reg skip_reg,
  output reg load_done_reg,
  output reg [`SRC_N-1:0] load_src_reg,
  output reg busy_reg
);

  ////////////////////////////////////////////////////////////////////////
  // Execution states, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_EXEC = 2'b10;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [ACC_W-1:0] acc_next;
  reg carry_flag_next;
  reg [`SRC_N-1:0] load_src_next;
  reg [ACC_W-1:0] src_data;

  wire [`SRC_N-1:0] src_sel;
  wire zero_fill_top;
  wire load_hit;
  wire [ACC_W-1:0] sp_ext;

  ////////////////////////////////////////////////////////////////////////
  // True when exactly one select bit is set
  function onehot_ok;
    input [`SRC_N-1:0] sel;
    integer i;
    reg [2:0] cnt;
    begin
      cnt = 3'd0;
      for (i = 0; i < `SRC_N; i = i + 1) begin
        cnt = cnt + {2'b00, sel[i]};
      end
      onehot_ok = (cnt == 3'd1);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Opcode decode
  acc_src_decode u_decode (
    .instr_word (instr_word),
    .instr_valid (instr_valid),
    .src_sel (src_sel),
    .zero_fill_top (zero_fill_top)
  );

  // A malformed select never loads anything
  assign load_hit = onehot_ok(src_sel);

  ////////////////////////////////////////////////////////////////////////
  // Stack pointer widened to accumulator width, top bits zero
  genvar g;
  generate
    for (g = 0; g < ACC_W; g = g + 1) begin : g_sp_ext
      if (g < SP_W) begin : g_copy
        assign sp_ext[g] = stack_pointer[g];
      end else begin : g_zero
        assign sp_ext[g] = 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Source mux; the buses are only read, never driven back
  always @* begin
    src_data = {ACC_W{1'b0}};
    case (1'b1)
      src_sel[`SEL_STACK_PTR]: begin
        src_data = sp_ext;
        if (zero_fill_top) begin
          src_data[ACC_W-1] = 1'b0;
        end
      end
      src_sel[`SEL_IRQ_CTRL_A]: begin
        src_data = irq_ctrl_a;
      end
      src_sel[`SEL_IRQ_CTRL_B]: begin
        src_data = irq_ctrl_b;
      end
      src_sel[`SEL_TMR_CTRL_A]: begin
        src_data = tmr_ctrl_a;
      end
      src_sel[`SEL_TMR_CTRL_B]: begin
        src_data = tmr_ctrl_b;
      end
      default: begin
        src_data = {ACC_W{1'b0}};
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Accumulator next value; a decoded load wins over the core's own write
  // since both cannot be legal in the same instruction slot
  always @* begin
    acc_next = acc_reg;
    if (load_hit) begin
      acc_next = src_data;
    end else if (acc_ext_wr) begin
      acc_next = acc_ext_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Carry is left alone by every load handled here
  always @* begin
    carry_flag_next = carry_flag_reg;
    if (carry_ext_wr && !load_hit) begin
      carry_flag_next = carry_ext_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Remember which source the last load used, for the core's trace
  always @* begin
    load_src_next = load_src_reg;
    if (load_hit) begin
      load_src_next = src_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Single-cycle execution: EXEC lasts exactly the cycle after a hit
  always @* begin
    state_next = ST_IDLE;
    case (state_reg)
      ST_IDLE: begin
        if (load_hit) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (load_hit) begin
          state_next = ST_EXEC; // Back-to-back loads allowed
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State and accumulator registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      acc_reg <= `ACC_RST;
      carry_flag_reg <= `CARRY_RST;
      load_src_reg <= `SEL_RST;
    end else begin
      state_reg <= state_next;
      acc_reg <= acc_next;
      carry_flag_reg <= carry_flag_next;
      load_src_reg <= load_src_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status outputs; skip is never requested by these loads
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      skip_reg <= 1'b0;
      load_done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      skip_reg <= 1'b0;
      load_done_reg <= load_hit;
      busy_reg <= (state_next == ST_EXEC);
    end
  end

endmodule // acc_load_core
`default_nettype wire

/* File: acc_load_defines.vh */
// Constants for the accumulator load-from-control-register decoder
`ifndef ACC_LOAD_DEFINES_VH
`define ACC_LOAD_DEFINES_VH

// Data path widths
`define ACC_W 4
`define INSTR_W 10
`define SP_W 3
`define SRC_N 5

// Instruction codes, ten bits wide
`define OP_LOAD_ACC_FROM_STACK_PTR 10'h050
`define OP_LOAD_ACC_FROM_IRQ_CTRL_A 10'h054
`define OP_LOAD_ACC_FROM_IRQ_CTRL_B 10'h055
`define OP_LOAD_ACC_FROM_TMR_CTRL_A 10'h24b
`define OP_LOAD_ACC_FROM_TMR_CTRL_B 10'h24c

// Bit positions of the one-hot source select
`define SEL_STACK_PTR 0
`define SEL_IRQ_CTRL_A 1
`define SEL_IRQ_CTRL_B 2
`define SEL_TMR_CTRL_A 3
`define SEL_TMR_CTRL_B 4

// Reset values
`define ACC_RST 4'h0
`define CARRY_RST 1'b0
`define SEL_RST 5'h00

// Every instruction handled here is one word and one cycle
`define LOAD_WORDS 1
`define LOAD_CYCLES 1

`endif

/* File: acc_src_decode.v */
// Opcode decoder that picks the accumulator load source
`timescale 1ns/1ps
`default_nettype none
`include "acc_load_defines.vh"

module acc_src_decode (
  input wire [`INSTR_W-1:0] instr_word,
  input wire instr_valid,
  output reg [`SRC_N-1:0] src_sel,
  output reg zero_fill_top
);

  ////////////////////////////////////////////////////////////////////////
  // Full ten-bit compare; any other code selects nothing
  always @* begin
    src_sel = `SEL_RST;
    zero_fill_top = 1'b0;
    if (instr_valid) begin
      case (instr_word)
        `OP_LOAD_ACC_FROM_STACK_PTR: begin
          src_sel[`SEL_STACK_PTR] = 1'b1;
          zero_fill_top = 1'b1;
        end
        `OP_LOAD_ACC_FROM_IRQ_CTRL_A: begin
          src_sel[`SEL_IRQ_CTRL_A] = 1'b1;
        end
        `OP_LOAD_ACC_FROM_IRQ_CTRL_B: begin
          src_sel[`SEL_IRQ_CTRL_B] = 1'b1;
        end
        `OP_LOAD_ACC_FROM_TMR_CTRL_A: begin
          src_sel[`SEL_TMR_CTRL_A] = 1'b1;
        end
        `OP_LOAD_ACC_FROM_TMR_CTRL_B: begin
          src_sel[`SEL_TMR_CTRL_B] = 1'b1;
        end
        default: begin
          src_sel = `SEL_RST;
        end
      endcase
    end
  end

endmodule // acc_src_decode
`default_nettype wire

/* File: acc_load_checker.sv */
// Assertions for the accumulator load decoder
`timescale 1ns/1ps
`default_nettype none
`include "acc_load_defines.vh"
module acc_load_checker #(parameter ACC_W = 4, parameter SP_W = 3) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [9:0] instr_word,
  input wire logic instr_valid,
  input wire logic [SP_W-1:0] stack_pointer,
  input wire logic [ACC_W-1:0] irq_ctrl_a,
  input wire logic [ACC_W-1:0] irq_ctrl_b,
  input wire logic [ACC_W-1:0] tmr_ctrl_a,
  input wire logic [ACC_W-1:0] tmr_ctrl_b,
  input wire logic [ACC_W-1:0] acc_reg,
  input wire logic carry_flag_reg,
  input wire logic skip_reg,
  input wire logic load_done_reg
);
  // Opcode hits, gated by valid
  wire sp_hit = instr_valid && instr_word == `OP_LOAD_ACC_FROM_STACK_PTR;
  wire ia_hit = instr_valid && instr_word == `OP_LOAD_ACC_FROM_IRQ_CTRL_A;
  wire ib_hit = instr_valid && instr_word == `OP_LOAD_ACC_FROM_IRQ_CTRL_B;
  wire ta_hit = instr_valid && instr_word == `OP_LOAD_ACC_FROM_TMR_CTRL_A;
  wire tb_hit = instr_valid && instr_word == `OP_LOAD_ACC_FROM_TMR_CTRL_B;
  wire any_hit = sp_hit | ia_hit | ib_hit | ta_hit | tb_hit;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  sp_copy_a: assert property (sp_hit |=> acc_reg[2:0] == $past(stack_pointer)) else $error("sp copy wrong");
  top_zero_a: assert property (sp_hit |=> !acc_reg[3]) else $error("acc bit3 not cleared");
  irq_a_a: assert property (ia_hit |=> acc_reg == $past(irq_ctrl_a)) else $error("irq a load wrong");
  irq_b_a: assert property (ib_hit |=> acc_reg == $past(irq_ctrl_b)) else $error("irq b load wrong");
  tmr_a_a: assert property (ta_hit |=> acc_reg == $past(tmr_ctrl_a)) else $error("tmr a load wrong");
  tmr_b_a: assert property (tb_hit |=> acc_reg == $past(tmr_ctrl_b)) else $error("tmr b load wrong");
  flags_keep_a: assert property (any_hit |=> $stable(carry_flag_reg) && !skip_reg) else $error("flag moved");
  done_pulse_a: assert property (any_hit |=> load_done_reg) else $error("no done pulse");
  // Main scenarios reached
  cover property (sp_hit);
  cover property (any_hit ##1 any_hit);
  cover property (instr_valid && !any_hit);
endmodule // acc_load_checker
bind acc_load_core acc_load_checker #(.ACC_W(ACC_W), .SP_W(SP_W)) u_acc_load_checker (.ref_clk, .rst_n,
  .instr_word, .instr_valid, .stack_pointer, .irq_ctrl_a, .irq_ctrl_b, .tmr_ctrl_a, .tmr_ctrl_b,
  .acc_reg, .carry_flag_reg, .skip_reg, .load_done_reg);
`default_nettype wire

/* File: acc_load_core_tb.sv */
// Self-checking bench for the accumulator load decoder
`timescale 1ns/1ps
`default_nettype none
`include "acc_load_defines.vh"
module acc_load_core_tb;
  logic ref_clk, rst_n, instr_valid, acc_ext_wr, carry_ext_wr, carry_ext_data;
  logic [9:0] instr_word;
  logic [2:0] stack_pointer;
  logic [3:0] irq_ctrl_a, irq_ctrl_b, tmr_ctrl_a, tmr_ctrl_b, acc_ext_data;
  wire [3:0] acc_reg;
  wire carry_flag_reg, skip_reg, load_done_reg, busy_reg;
  wire [4:0] load_src_reg;
  int failures = 0;
  int cmp_count = 0;
  // Rows: opcode beside the accumulator it should give
  logic [13:0] rows [5] = '{{`OP_LOAD_ACC_FROM_STACK_PTR, 4'h6}, {`OP_LOAD_ACC_FROM_IRQ_CTRL_A, 4'h9},
    {`OP_LOAD_ACC_FROM_IRQ_CTRL_B, 4'h5}, {`OP_LOAD_ACC_FROM_TMR_CTRL_A, 4'hc}, {`OP_LOAD_ACC_FROM_TMR_CTRL_B, 4'h3}};
  logic [3:0] expb [5] = '{4'h1, 4'h6, 4'ha, 4'h3, 4'hc};
  acc_load_core u_acc_load_core (.ref_clk, .rst_n, .instr_word, .instr_valid, .stack_pointer, .irq_ctrl_a,
    .irq_ctrl_b, .tmr_ctrl_a, .tmr_ctrl_b, .acc_ext_wr, .acc_ext_data, .carry_ext_wr, .carry_ext_data,
    .acc_reg, .carry_flag_reg, .skip_reg, .load_done_reg, .load_src_reg, .busy_reg);
  ////////////////////////////////////////////////////////////////
  // Clock, 50 ns period
  initial begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic [4:0] e, input logic [4:0] s);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence, inputs change on the falling edge
  initial begin
    {rst_n, instr_valid, acc_ext_wr, carry_ext_wr, carry_ext_data, acc_ext_data, instr_word} = '0;
    {stack_pointer, irq_ctrl_a, irq_ctrl_b, tmr_ctrl_a, tmr_ctrl_b} = {3'h6, 16'h95c3};
    repeat (16) @(negedge ref_clk);
    rst_n = 1;
    // Preload acc f and carry 1, then load while the core paths try to write
    foreach (rows[i]) begin
      @(negedge ref_clk);
      {acc_ext_wr, acc_ext_data, carry_ext_wr, carry_ext_data} = 7'h7f;
      @(negedge ref_clk);
      {acc_ext_data, carry_ext_data, instr_valid} = 6'h01;
      instr_word = rows[i][13:4];
      @(negedge ref_clk);
      {acc_ext_wr, carry_ext_wr, instr_valid} = 3'h0;
      chk("acc", rows[i][3:0], acc_reg);
      chk("carry", 1, carry_flag_reg);
      chk("skip", 0, skip_reg);
      chk("done", 1, load_done_reg);
      chk("busy", 1, busy_reg);
      chk("src", 5'h1 << i, load_src_reg);
    end
    $display("test rows done");
    // Back to back loads with new source values; one idle edge so valid is not set twice at once
    @(negedge ref_clk);
    {stack_pointer, irq_ctrl_a, irq_ctrl_b, tmr_ctrl_a, tmr_ctrl_b} = {3'h1, 16'h6a3c};
    instr_valid = 1;
    foreach (rows[i]) begin
      instr_word = rows[i][13:4];
      @(negedge ref_clk);
      chk("b2b acc", expb[i], acc_reg);
    end
    $display("test back to back done");
    // Unknown opcode leaves acc alone
    instr_word = 10'h052;
    @(negedge ref_clk);
    instr_valid = 0;
    chk("other acc", 4'hc, acc_reg);
    chk("other done", 0, load_done_reg);
    $display("test unknown opcode done");
    // Reset in mid-run, just after a load has raised done and busy
    @(negedge ref_clk);
    instr_word = `OP_LOAD_ACC_FROM_STACK_PTR;
    instr_valid = 1;
    @(negedge ref_clk);
    instr_valid = 0;
    chk("pre acc", 4'h1, acc_reg);
    rst_n = 0;
    #1;
    chk("rst acc", 0, acc_reg);
    chk("rst carry", 0, carry_flag_reg);
    chk("rst done", 0, load_done_reg);
    chk("rst busy", 0, busy_reg);
    chk("rst src", 0, load_src_reg);
    @(negedge ref_clk);
    rst_n = 1;
    // First load taken at the first edge after release
    instr_word = `OP_LOAD_ACC_FROM_TMR_CTRL_B;
    instr_valid = 1;
    @(negedge ref_clk);
    instr_valid = 0;
    chk("post acc", 4'hc, acc_reg);
    chk("post src", 5'h10, load_src_reg);
    chk("post done", 1, load_done_reg);
    // Done and busy stand for one cycle only
    @(negedge ref_clk);
    chk("post done low", 0, load_done_reg);
    chk("post busy low", 0, busy_reg);
    chk("post acc kept", 4'hc, acc_reg);
    $display("test reset done");
    wrap_up();
  end
  // Watchdog, far beyond the few dozen cycles needed
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
endmodule // acc_load_core_tb
`default_nettype wire
